/* File: rsadc_defs.svh */
// Constants for the differential port direction control block.
`ifndef RSADC_DEFS_SVH
`define RSADC_DEFS_SVH
// Baud tick divider parameters.
`define RSADC_DIV_W 16
// Bits per character used for the hold time (start, 8 data, parity, 2 stop).
`define RSADC_CHAR_BITS 9'h00C
// UART samples sixteen ticks per bit.
`define RSADC_TICKS_PER_BIT 9'h010
// Store depth per direction.
`define RSADC_FIFO_DEPTH 16
`define RSADC_FIFO_AW 4
`define RSADC_CNT_W 5
// Default divisor for 115,200 baud from the 200 MHz clock at 16 ticks per bit.
`define RSADC_DIV_1X 16'h006C
`endif

/* File: rsadc_pkg.sv */
// Types for the differential port direction control block.
`default_nettype none
package rsadc_pkg;
    typedef enum logic [1:0]
    {
        RSADC_IDLE = 2'b00,
        RSADC_SEND = 2'b01,
        RSADC_HOLD = 2'b11
    } rsadc_state_e;
endpackage
`default_nettype wire

/* File: rsadc_ctrl.sv */
// Automatic driver and receiver direction control with character stores.
`timescale 1ns/1ps
`default_nettype none
`include "rsadc_defs.svh"
module rsadc_ctrl
    import rsadc_pkg::*;
(
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Configuration.
    input wire logic [`RSADC_DIV_W-1:0] i_baud_div,
    input wire logic i_clk_x4,
    input wire logic i_full_duplex,
    // Transmit side, from software.
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready,
    // Transmit side, towards the UART shifter.
    output logic o_shift_valid,
    output logic [7:0] o_shift_data,
    input wire logic i_shift_take,
    input wire logic i_shift_busy,
    // Receive side.
    input wire logic i_rx_line,
    output logic o_rx_line,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_rx_ready,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    input wire logic i_rd_take,
    // Transceiver controls.
    output logic o_drv_en,
    output logic o_rcv_en,
    output logic o_baud_tick
);

    function automatic logic [`RSADC_FIFO_AW-1:0] ptr_inc(input logic [`RSADC_FIFO_AW-1:0] p);
        ptr_inc = p + 4'h1;
    endfunction

    // ======================================================
    // Baud tick divider.
    // ======================================================
    logic [`RSADC_DIV_W-1:0] div_cnt, next_div_cnt, div_load;
    logic tick, next_tick;
    always_comb
    begin
        // The x4 option shortens the divisor, so hold time tracks the faster clock.
        div_load = i_clk_x4 ? {2'b00, i_baud_div[`RSADC_DIV_W-1:2]} : i_baud_div;
        if (div_load == 16'h0000)
        begin
            div_load = 16'h0001;
        end
        next_tick = 1'b0;
        next_div_cnt = div_cnt - 16'h0001;
        if (div_cnt <= 16'h0001)
        begin
            next_div_cnt = div_load;
            next_tick = 1'b1;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            div_cnt <= 16'h0001;
            tick <= 1'b0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
            tick <= next_tick;
        end
    end

    // ======================================================
    // Transmit and receive stores.
    // ======================================================
    logic [7:0] tx_mem [`RSADC_FIFO_DEPTH];
    logic [7:0] rx_mem [`RSADC_FIFO_DEPTH];
    logic [`RSADC_FIFO_AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
    logic [`RSADC_FIFO_AW-1:0] next_tx_wp, next_tx_rp, next_rx_wp, next_rx_rp;
    logic [`RSADC_CNT_W-1:0] tx_cnt, rx_cnt, next_tx_cnt, next_rx_cnt;
    logic tx_push, tx_pop, rx_push, rx_pop;
    // Flags are registered so that every top-level output comes from a flop.
    logic tx_rdy, rx_rdy, sh_vld, rd_vld;
    logic next_tx_rdy, next_rx_rdy, next_sh_vld, next_rd_vld;
    always_comb
    begin
        tx_push = i_tx_valid && o_tx_ready;
        tx_pop = i_shift_take && o_shift_valid;
        rx_push = i_rx_valid && o_rx_ready && o_rcv_en;
        rx_pop = i_rd_take && o_rd_valid;
        next_tx_wp = tx_push ? ptr_inc(tx_wp) : tx_wp;
        next_tx_rp = tx_pop ? ptr_inc(tx_rp) : tx_rp;
        next_rx_wp = rx_push ? ptr_inc(rx_wp) : rx_wp;
        next_rx_rp = rx_pop ? ptr_inc(rx_rp) : rx_rp;
        next_tx_cnt = tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
        next_rx_cnt = rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
        next_tx_rdy = (next_tx_cnt != 5'h10);
        next_rx_rdy = (next_rx_cnt != 5'h10);
        next_sh_vld = (next_tx_cnt != 5'h00);
        next_rd_vld = (next_rx_cnt != 5'h00);
    end
    always_ff @(posedge i_sys_clk)
    begin
        if (tx_push)
        begin
            tx_mem[tx_wp] <= i_tx_data;
        end
        if (rx_push)
        begin
            rx_mem[rx_wp] <= i_rx_data;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_wp <= 4'h0;
            tx_rp <= 4'h0;
            rx_wp <= 4'h0;
            rx_rp <= 4'h0;
            tx_cnt <= 5'h00;
            rx_cnt <= 5'h00;
            o_shift_data <= 8'h00;
            o_rd_data <= 8'h00;
            tx_rdy <= 1'b1;
            rx_rdy <= 1'b1;
            sh_vld <= 1'b0;
            rd_vld <= 1'b0;
        end
        else
        begin
            tx_wp <= next_tx_wp;
            tx_rp <= next_tx_rp;
            rx_wp <= next_rx_wp;
            rx_rp <= next_rx_rp;
            tx_cnt <= next_tx_cnt;
            rx_cnt <= next_rx_cnt;
            tx_rdy <= next_tx_rdy;
            rx_rdy <= next_rx_rdy;
            sh_vld <= next_sh_vld;
            rd_vld <= next_rd_vld;
            // Head word is registered so outputs come straight from flops.
            o_shift_data <= (tx_push && next_tx_cnt == 5'h01) ? i_tx_data : tx_mem[next_tx_rp];
            o_rd_data <= (rx_push && next_rx_cnt == 5'h01) ? i_rx_data : rx_mem[next_rx_rp];
        end
    end
    always_comb
    begin
        o_tx_ready = tx_rdy;
        o_rx_ready = rx_rdy;
        o_shift_valid = sh_vld;
        o_rd_valid = rd_vld;
    end

    // ======================================================
    // Direction control.
    // ======================================================
    // A full character is counted in baud ticks, so the hold scales with any rate.
    rsadc_state_e state, next_state;
    logic [8:0] hold_cnt, next_hold_cnt;
    logic drv_en, next_drv_en, rcv_en, next_rcv_en, rxl, next_rxl;
    logic pending;
    always_comb
    begin
        pending = o_shift_valid || i_shift_busy || tx_push;
        next_state = state;
        next_hold_cnt = hold_cnt;
        case (state)
            RSADC_IDLE:
            begin
                if (pending)
                begin
                    next_state = RSADC_SEND;
                end
            end
            RSADC_SEND:
            begin
                if (!pending)
                begin
                    next_state = RSADC_HOLD;
                    next_hold_cnt = 9'(`RSADC_CHAR_BITS * `RSADC_TICKS_PER_BIT);
                end
            end
            RSADC_HOLD:
            begin
                if (pending)
                begin
                    next_state = RSADC_SEND;
                end
                else if (tick)
                begin
                    next_hold_cnt = hold_cnt - 9'h001;
                    if (hold_cnt == 9'h001)
                    begin
                        next_state = RSADC_IDLE;
                    end
                end
            end
            default:
            begin
                next_state = RSADC_IDLE;
            end
        endcase
        // Full duplex bypasses direction control entirely.
        next_drv_en = i_full_duplex || (next_state != RSADC_IDLE);
        next_rcv_en = i_full_duplex || !next_drv_en;
        next_rxl = next_rcv_en ? i_rx_line : 1'b1;
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= RSADC_IDLE;
            hold_cnt <= 9'h000;
            drv_en <= 1'b0;
            rcv_en <= 1'b1;
            rxl <= 1'b1;
        end
        else
        begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            drv_en <= next_drv_en;
            rcv_en <= next_rcv_en;
            rxl <= next_rxl;
        end
    end
    always_comb
    begin
        o_drv_en = drv_en;
        o_rcv_en = rcv_en;
        o_rx_line = rxl;
        o_baud_tick = tick;
    end

endmodule
`default_nettype wire

/* File: rsadc_ctrl_assertions.sv */
// Checker for the direction control block.
`timescale 1ns/1ps
`default_nettype none
module rsadc_ctrl_chk (
    // Clock, reset and mode.
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_full_duplex,
    // Data paths.
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    input wire logic o_tx_ready,
    input wire logic o_shift_valid,
    input wire logic [7:0] o_shift_data,
    input wire logic i_shift_busy,
    input wire logic i_rx_valid,
    input wire logic o_rx_line,
    input wire logic o_rd_valid,
    // Transceiver controls.
    input wire logic o_drv_en,
    input wire logic o_rcv_en,
    input wire logic o_baud_tick
);
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    // ====
    // Ticks counted since the port last had anything to send.
    logic [8:0] idle;
    // A fresh push restarts the count, since the driver comes on at that same edge.
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            idle <= 9'h000;
        end
        else if (i_shift_busy || o_shift_valid || i_full_duplex || (i_tx_valid && o_tx_ready))
        begin
            idle <= 9'h000;
        end
        else if (o_baud_tick && idle != 9'h1FF)
        begin
            idle <= idle + 9'h001;
        end
    end
    chk_drv_push: assert property (i_tx_valid && o_tx_ready |=> o_drv_en)
        else $error("driver off after push");
    chk_drv_busy: assert property (i_shift_busy |=> o_drv_en)
        else $error("driver off while shifting");
    chk_hold_min: assert property ($fell(o_drv_en) |-> idle >= 9'h0BE)
        else $error("driver released early");
    chk_hold_max: assert property (idle > 9'h0C3 |-> !o_drv_en)
        else $error("driver held too long");
    chk_rcv_gate: assert property (!i_full_duplex && !$past(i_full_duplex)
        |-> o_rcv_en != o_drv_en)
        else $error("receiver not gated");
    chk_echo_block: assert property (!o_rcv_en && !$past(o_rcv_en) |-> o_rx_line)
        else $error("echo passed");
    chk_rx_drop: assert property (i_rx_valid && !o_rcv_en && !o_rd_valid |=> !o_rd_valid)
        else $error("rx push not dropped");
    chk_full_dup: assert property (i_full_duplex && $past(i_full_duplex)
        |-> o_drv_en && o_rcv_en)
        else $error("full duplex not both on");
    chk_head_data: assert property (i_tx_valid && o_tx_ready && !o_shift_valid
        |=> o_shift_valid && o_shift_data == $past(i_tx_data))
        else $error("head byte wrong");
endmodule
bind rsadc_ctrl rsadc_ctrl_chk u_rsadc_ctrl_chk (.*);
`default_nettype wire

/* File: rsadc_node.sv */
// Model of the UART shifter facing the shared pair.
`timescale 1ns/1ps
`default_nettype none
module rsadc_node (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Shifter handshake.
    input wire logic i_shift_valid,
    input wire logic [9:0] i_busy_len,
    output logic o_take,
    output logic o_busy
);
    logic [9:0] left;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            left <= 10'h000;
            o_take <= 1'b0;
        end
        else
        begin
            o_take <= left == 10'h000 && i_shift_valid && !o_take;
            left <= o_take ? i_busy_len : left - {9'h000, o_busy};
        end
    end
    assign o_busy = left != 10'h000;
endmodule
`default_nettype wire

/* File: test_rs485_auto_driver_control.sv */
// Self-checking bench for the direction control block.
`timescale 1ns/1ps
`default_nettype none
module test_rs485_auto_driver_control;
    logic clk = 1'b0, rst_n = 1'b0, x4 = 1'b0, fd = 1'b0, tv = 1'b0, rv = 1'b0;
    logic dt = 1'b0, rxl = 1'b1, tr, sv, tk, bz, rxo, rr, dv, de, re, bt;
    logic [15:0] div = 16'h0002;
    logic [9:0] blen = 10'h01E;
    logic [7:0] td = 8'h00, rd = 8'h00, sd, dd;
    int fail_count = 0, n_tests = 0, c;
    always #2.5 clk = ~clk;
    rsadc_ctrl u_rsadc_ctrl (.i_sys_clk(clk), .i_rst_n(rst_n), .i_baud_div(div),
        .i_clk_x4(x4), .i_full_duplex(fd), .i_tx_valid(tv), .i_tx_data(td), .o_tx_ready(tr),
        .o_shift_valid(sv), .o_shift_data(sd), .i_shift_take(tk), .i_shift_busy(bz),
        .i_rx_line(rxl), .o_rx_line(rxo), .i_rx_valid(rv), .i_rx_data(rd), .o_rx_ready(rr),
        .o_rd_valid(dv), .o_rd_data(dd), .i_rd_take(dt), .o_drv_en(de), .o_rcv_en(re),
        .o_baud_tick(bt));
    rsadc_node u_rsadc_node (.i_sys_clk(clk), .i_rst_n(rst_n), .i_shift_valid(sv),
        .i_busy_len(blen), .o_take(tk), .o_busy(bz));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL %0t got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int lo, input int hi);
        n_tests++;
        if (c < lo || c > hi)
        begin
            fail_count++;
            $display("FAIL %0t count %0d", $time, c);
        end
    endtask
    task automatic end_of_test();
        $display("fails %0d checks %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Counts idle cycles after the shifter goes quiet until the driver drops.
    task automatic wait_idle();
        c = 0;
        for (int k = 0; k < 4000 && de !== 1'b0; k++)
        begin
            c = bz ? 0 : c + 1;
            step(1);
        end
        if (de !== 1'b0)
        begin
            fail_count++;
            $display("FAIL %0t driver never released", $time);
            end_of_test();
        end
    endtask
    task automatic t_fill();
        int n = 0;
        tv = 1'b1;
        for (int i = 0; i < 20 && tr === 1'b1; i++)
        begin
            td = td + 8'h01;
            n++;
            step(1);
        end
        tv = 1'b0;
        chk(n, 17);
        chk(de, 1);
        chk(re, 0);
        rxl = 1'b0;
        rv = 1'b1;
        step(2);
        rv = 1'b0;
        chk(dv, 0);
        chk(rxo, 1);
        rxl = 1'b1;
        wait_idle();
        chk_rng(380, 390);
    endtask
    task automatic t_hold(input logic [15:0] d, input logic x, input int lo, input int hi);
        div = d;
        x4 = x;
        blen = 10'h00A;
        tv = 1'b1;
        step(1);
        tv = 1'b0;
        step(1);
        chk(de, 1);
        chk(sd, td);
        wait_idle();
        chk_rng(lo, hi);
        chk(re, 1);
    endtask
    task automatic t_rx();
        rxl = 1'b0;
        rv = 1'b1;
        rd = 8'hC3;
        step(1);
        rv = 1'b0;
        step(1);
        chk(rxo, 0);
        chk(dv, 1);
        chk(dd, 10'h0C3);
        dt = 1'b1;
        step(1);
        dt = 1'b0;
        chk(dv, 0);
        rxl = 1'b1;
    endtask
    // Fills the receive store to its depth, then drains it in order.
    task automatic t_rx_fill();
        rv = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            rd = 8'(i);
            step(1);
        end
        rv = 1'b0;
        chk(rr, 0);
        chk(dv, 1);
        dt = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            chk(dd, 10'(i));
            step(1);
        end
        dt = 1'b0;
        chk(dv, 0);
        chk(rr, 1);
    endtask
    // Counts baud ticks over a fixed window at a known divisor.
    task automatic t_tick();
        div = 16'h0004;
        x4 = 1'b0;
        step(8);
        c = 0;
        for (int k = 0; k < 40; k++)
        begin
            c = (bt === 1'b1) ? c + 1 : c;
            step(1);
        end
        chk_rng(10, 10);
    endtask
    task automatic t_full();
        fd = 1'b1;
        step(2);
        tv = 1'b1;
        rv = 1'b1;
        step(1);
        tv = 1'b0;
        rv = 1'b0;
        step(1);
        chk(de, 1);
        chk(re, 1);
        chk(dv, 1);
    endtask
    initial
    begin
        step(10);
        rst_n = 1'b1;
        step(1);
        t_fill();
        t_hold(16'h0004, 1'b0, 764, 774);
        t_hold(16'h0008, 1'b1, 380, 390);
        t_rx();
        t_rx_fill();
        t_tick();
        t_full();
        end_of_test();
    end
endmodule
`default_nettype wire
